// ==== src/rtcai_pkg.sv ====
package rtcai_pkg;

  // Register indexes; the byte address on APB is four times the index
  localparam logic [7:0] IDX_CTRL = 8'h01;
  localparam logic [7:0] IDX_MIN_CNT = 8'h03;
  localparam logic [7:0] IDX_HOUR_CNT = 8'h04;
  localparam logic [7:0] IDX_DAY_CNT = 8'h05;
  localparam logic [7:0] IDX_WDAY_CNT = 8'h06;
  localparam logic [7:0] IDX_MIN_MATCH = 8'h09;
  localparam logic [7:0] IDX_HOUR_MATCH = 8'h0A;
  localparam logic [7:0] IDX_DAY_MATCH = 8'h0B;
  localparam logic [7:0] IDX_WDAY_MATCH = 8'h0C;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h10;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h11;
  localparam logic [7:0] IDX_PIN_STAT = 8'h12;

  // Control and flag bit positions
  localparam int unsigned CTRL_TIE_BIT = 0;
  localparam int unsigned CTRL_AIE_BIT = 1;
  localparam int unsigned CTRL_TF_BIT = 2;
  localparam int unsigned CTRL_AF_BIT = 3;
  localparam int unsigned CTRL_TPS_BIT = 4;

  // Mask bit in the top position of each match register
  localparam int unsigned MATCH_MASK_BIT = 7;

  // Implemented BCD digit bits of each field
  localparam logic [7:0] MIN_DIGITS = 8'h7F;
  localparam logic [7:0] HOUR_DIGITS = 8'h3F;
  localparam logic [7:0] DAY_DIGITS = 8'h3F;
  localparam logic [7:0] WDAY_DIGITS = 8'h07;

  // Interrupt status and mask bit positions
  localparam int unsigned IRQ_ALARM_BIT = 0;
  localparam int unsigned IRQ_TIMER_BIT = 1;
  localparam int unsigned IRQ_BITS = 2;

  // Reset values
  localparam logic [7:0] MATCH_RESET = 8'h80;
  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // Alarm evaluation sequencer
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EVAL = 2'b10
  } rtcai_state_e;

endpackage

// ==== src/rtcai_alarm.sv ====
// Our own choice: the APB slave port.
`timescale 1ns/100ps

// Functional notes
// R1: An alarm event is raised when every unmasked minute, hour, day and weekday match field equals the current time.
// R2: A match field whose top mask bit is one is left out of the comparison entirely.
// R3: With all four mask bits set no alarm event is ever raised.
// R4: An alarm event sets the alarm flag, which stays set until software clears it.
// R5: Writing zero to the alarm flag clears it and writing one leaves it alone.
// R6: With the alarm interrupt enable set, an alarm event pulls the interrupt pin low.
// R7: With the alarm interrupt enable clear, the alarm never holds the pin low and a low pin is released.
// R8: Setting the enable while the alarm flag is still set pulls the pin low at once.
// R9: Clearing the alarm flag releases a low pin caused by the alarm.
// R10: The pin is shared, low when either an enabled timer flag or an enabled alarm flag is set.
// R11: The hour field is compared on a 24-hour basis, like the hour counter.
// R12: An event is raised only on entry into the matching condition, not while it persists.
// R13: Software that wants polling only keeps the enable at zero and watches the alarm flag rise.
// R14: Software should clear the enable before changing alarm settings.
// R15: Once low from an alarm, the pin stays low until the flag or the enable is cleared.
// R16: Fields are compared as BCD using only the implemented digit bits.
// R17: The match is evaluated once per minute update of the time counters.
module rtcai_alarm
  import rtcai_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic time_tick,
  input wire logic [7:0] time_minute,
  input wire logic [7:0] time_hour,
  input wire logic [7:0] time_day,
  input wire logic [7:0] time_weekday,
  input wire logic timer_event,
  output logic timer_pulse_select,
  input wire logic alarm_irq_in,
  output logic alarm_irq_out_n,
  output logic alarm_irq_oe,
  output logic irq
);

  // Byte address of a register index
  function automatic logic [7:0] reg_addr(input logic [7:0] idx);
    reg_addr = {idx[5:0], 2'b00};
  endfunction

  // One field compares true when masked or when its digit bits agree
  function automatic logic field_hit(input logic [7:0] match_val,
                                     input logic [7:0] cur_val,
                                     input logic [7:0] digits);
    field_hit = match_val[MATCH_MASK_BIT] |
                ((match_val & digits) == (cur_val & digits));
  endfunction

  logic [7:0] min_cnt_reg;
  logic [7:0] hour_cnt_reg;
  logic [7:0] day_cnt_reg;
  logic [7:0] wday_cnt_reg;
  logic [7:0] min_match_reg;
  logic [7:0] hour_match_reg;
  logic [7:0] day_match_reg;
  logic [7:0] wday_match_reg;
  logic aie_reg;
  logic tie_reg;
  logic tps_reg;
  logic af_reg;
  logic af_next;
  logic tf_reg;
  logic tf_next;
  logic match_prev_reg;
  logic [IRQ_BITS-1:0] irq_stat_reg;
  logic [IRQ_BITS-1:0] irq_stat_next;
  logic [IRQ_BITS-1:0] irq_mask_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rd_mux;
  rtcai_state_e state_reg;
  rtcai_state_e state_next;

  // APB phase decode
  wire apb_setup = psel & ~penable;
  wire apb_access = psel & penable;
  wire apb_wr = apb_access & pwrite;
  wire apb_rd_setup = apb_setup & ~pwrite;

  // Address decode
  wire hit_ctrl = (paddr == reg_addr(IDX_CTRL));
  wire hit_min_cnt = (paddr == reg_addr(IDX_MIN_CNT));
  wire hit_hour_cnt = (paddr == reg_addr(IDX_HOUR_CNT));
  wire hit_day_cnt = (paddr == reg_addr(IDX_DAY_CNT));
  wire hit_wday_cnt = (paddr == reg_addr(IDX_WDAY_CNT));
  wire hit_min_match = (paddr == reg_addr(IDX_MIN_MATCH));
  wire hit_hour_match = (paddr == reg_addr(IDX_HOUR_MATCH));
  wire hit_day_match = (paddr == reg_addr(IDX_DAY_MATCH));
  wire hit_wday_match = (paddr == reg_addr(IDX_WDAY_MATCH));
  wire hit_irq_stat = (paddr == reg_addr(IDX_IRQ_STAT));
  wire hit_irq_mask = (paddr == reg_addr(IDX_IRQ_MASK));
  wire hit_pin_stat = (paddr == reg_addr(IDX_PIN_STAT));
  wire mapped = hit_ctrl | hit_min_cnt | hit_hour_cnt | hit_day_cnt |
                hit_wday_cnt | hit_min_match | hit_hour_match |
                hit_day_match | hit_wday_match | hit_irq_stat |
                hit_irq_mask | hit_pin_stat;

  // Write strobes, taken only at the access edge
  wire wr_ctrl = apb_wr & hit_ctrl;
  wire wr_irq_stat = apb_wr & hit_irq_stat;
  wire af_clear = wr_ctrl & ~pwdata[CTRL_AF_BIT];
  wire tf_clear = wr_ctrl & ~pwdata[CTRL_TF_BIT];

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = apb_access & ~mapped;
  assign prdata = prdata_reg;

  // Field comparison; hour is a plain 24-hour BCD value, no AM/PM bit
  wire min_hit = field_hit(min_match_reg, min_cnt_reg, MIN_DIGITS); // [R16]
  wire hour_hit = field_hit(hour_match_reg, hour_cnt_reg, HOUR_DIGITS); // [R11]
  wire day_hit = field_hit(day_match_reg, day_cnt_reg, DAY_DIGITS); // [R2]
  wire wday_hit = field_hit(wday_match_reg, wday_cnt_reg, WDAY_DIGITS);
  wire all_masked = min_match_reg[MATCH_MASK_BIT] &
                    hour_match_reg[MATCH_MASK_BIT] &
                    day_match_reg[MATCH_MASK_BIT] &
                    wday_match_reg[MATCH_MASK_BIT];
  wire match_now = min_hit & hour_hit & day_hit & wday_hit & // [R1]
                   ~all_masked; // [R3]

  // Event only on entry into the match, once per minute update
  wire alarm_event = (state_reg == ST_EVAL) & // [R17]
                     match_now & ~match_prev_reg; // [R12]

  // Flags: a hardware set in the clearing cycle wins over the clear
  assign af_next = alarm_event | (af_reg & ~af_clear); // [R4] [R5]
  assign tf_next = timer_event | (tf_reg & ~tf_clear);

  // Sticky interrupt status, write one to clear, set wins
  wire [IRQ_BITS-1:0] irq_events = {timer_event, alarm_event};
  wire [IRQ_BITS-1:0] irq_w1c = wr_irq_stat ? pwdata[IRQ_BITS-1:0] :
                                {IRQ_BITS{1'b0}};
  assign irq_stat_next = irq_events | (irq_stat_reg & ~irq_w1c);
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // Shared open-drain pin; only ever pulled low, level follows the flags
  wire alarm_pull = af_reg & aie_reg; // [R6] [R7] [R8] [R9] [R15]
  wire timer_pull = tf_reg & tie_reg;
  assign alarm_irq_out_n = 1'b0;
  assign alarm_irq_oe = alarm_pull | timer_pull; // [R10]
  assign timer_pulse_select = tps_reg;

  // Sequencer: compare one cycle after the counters take a new minute
  always_comb
  begin
    case (state_reg)
      ST_IDLE: state_next = time_tick ? ST_EVAL : ST_IDLE;
      ST_EVAL: state_next = time_tick ? ST_EVAL : ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  // Read data selection, unmapped reads return zero
  wire [7:0] ctrl_rd = {3'b000, tps_reg, af_reg, tf_reg, aie_reg, tie_reg};
  assign rd_mux =
    hit_ctrl ? {24'h00_0000, ctrl_rd} :
    hit_min_cnt ? {24'h00_0000, min_cnt_reg} :
    hit_hour_cnt ? {24'h00_0000, hour_cnt_reg} :
    hit_day_cnt ? {24'h00_0000, day_cnt_reg} :
    hit_wday_cnt ? {24'h00_0000, wday_cnt_reg} :
    hit_min_match ? {24'h00_0000, min_match_reg} :
    hit_hour_match ? {24'h00_0000, hour_match_reg} :
    hit_day_match ? {24'h00_0000, day_match_reg} :
    hit_wday_match ? {24'h00_0000, wday_match_reg} :
    hit_irq_stat ? {30'h0000_0000, irq_stat_reg} :
    hit_irq_mask ? {30'h0000_0000, irq_mask_reg} :
    hit_pin_stat ? {31'h0000_0000, alarm_irq_in} :
    RDATA_RESET;

  // Read data is captured in setup so the access phase sees a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_reg <= RDATA_RESET;
    else if (apb_rd_setup)
      prdata_reg <= rd_mux;
  end

  // Control, flags and sequencer state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      aie_reg <= 1'b0;
      tie_reg <= 1'b0;
      tps_reg <= 1'b0;
      af_reg <= 1'b0;
      tf_reg <= 1'b0;
      state_reg <= ST_IDLE;
    end
    else
    begin
      if (wr_ctrl)
      begin
        aie_reg <= pwdata[CTRL_AIE_BIT];
        tie_reg <= pwdata[CTRL_TIE_BIT];
        tps_reg <= pwdata[CTRL_TPS_BIT];
      end
      af_reg <= af_next;
      tf_reg <= tf_next;
      state_reg <= state_next;
    end
  end

  // Previous match only moves at an evaluation, so settings edits
  // between minutes cannot fake an entry into the match
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      match_prev_reg <= 1'b0;
    else if (state_reg == ST_EVAL)
      match_prev_reg <= match_now; // [R12]
  end

  // Interrupt status and mask
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat_reg <= {IRQ_BITS{1'b0}};
      irq_mask_reg <= {IRQ_BITS{1'b0}};
    end
    else
    begin
      irq_stat_reg <= irq_stat_next;
      if (apb_wr & hit_irq_mask)
        irq_mask_reg <= pwdata[IRQ_BITS-1:0];
    end
  end

  // Time counters: the minute update wins over a software write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      min_cnt_reg <= CNT_RESET;
      hour_cnt_reg <= CNT_RESET;
      day_cnt_reg <= CNT_RESET;
      wday_cnt_reg <= CNT_RESET;
    end
    else if (time_tick)
    begin
      min_cnt_reg <= time_minute;
      hour_cnt_reg <= time_hour;
      day_cnt_reg <= time_day;
      wday_cnt_reg <= time_weekday;
    end
    else
    begin
      if (apb_wr & hit_min_cnt)
        min_cnt_reg <= pwdata[7:0];
      if (apb_wr & hit_hour_cnt)
        hour_cnt_reg <= pwdata[7:0];
      if (apb_wr & hit_day_cnt)
        day_cnt_reg <= pwdata[7:0];
      if (apb_wr & hit_wday_cnt)
        wday_cnt_reg <= pwdata[7:0];
    end
  end

  // Match registers; reset with every field masked, so no alarm
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      min_match_reg <= MATCH_RESET;
      hour_match_reg <= MATCH_RESET;
      day_match_reg <= MATCH_RESET;
      wday_match_reg <= MATCH_RESET;
    end
    else
    begin
      if (apb_wr & hit_min_match)
        min_match_reg <= pwdata[7:0];
      if (apb_wr & hit_hour_match)
        hour_match_reg <= pwdata[7:0];
      if (apb_wr & hit_day_match)
        day_match_reg <= pwdata[7:0];
      if (apb_wr & hit_wday_match)
        wday_match_reg <= pwdata[7:0];
    end
  end

  // Checks on the alarm path
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  alarm_sets_flag_a: assert property ( // [R4]
    alarm_event |=> af_reg)
    else $error("alarm flag not set after alarm event");

  flag_holds_a: assert property ( // [R4]
    af_reg && !af_clear |=> af_reg)
    else $error("alarm flag dropped without a clearing write");

  zero_write_clears_a: assert property ( // [R5]
    af_reg && af_clear && !alarm_event |=> !af_reg)
    else $error("writing zero did not clear the alarm flag");

  one_write_keeps_a: assert property ( // [R5]
    af_reg && wr_ctrl && pwdata[CTRL_AF_BIT] |=> af_reg)
    else $error("writing one disturbed the alarm flag");

  enabled_pulls_low_a: assert property ( // [R6]
    alarm_event && aie_reg && !(wr_ctrl && !pwdata[CTRL_AIE_BIT])
    |=> alarm_irq_oe && !alarm_irq_out_n)
    else $error("enabled alarm did not pull the pin low");

  disabled_releases_a: assert property ( // [R7]
    !aie_reg && !timer_pull |-> !alarm_irq_oe)
    else $error("pin held low by a disabled alarm");

  enable_rise_a: assert property ( // [R8]
    $rose(aie_reg) && af_reg |-> alarm_irq_oe)
    else $error("enable rise with flag set left pin released");

  flag_clear_release_a: assert property ( // [R9]
    af_reg && aie_reg && af_clear && !alarm_event && !timer_pull
    ##1 !timer_pull |-> !alarm_irq_oe)
    else $error("clearing the flag did not release the pin");

  shared_pin_a: assert property ( // [R10]
    tf_reg && tie_reg |-> alarm_irq_oe)
    else $error("enabled timer flag did not pull the shared pin");

  low_until_clear_a: assert property ( // [R15]
    alarm_pull && !af_clear && !(wr_ctrl && !pwdata[CTRL_AIE_BIT])
    |=> alarm_irq_oe)
    else $error("alarm pin released without flag or enable clear");

  all_masked_quiet_a: assert property ( // [R3]
    all_masked |-> !alarm_event)
    else $error("alarm event with all fields masked");

  minute_field_a: assert property ( // [R1]
    alarm_event && !min_match_reg[MATCH_MASK_BIT]
    |-> (min_match_reg & MIN_DIGITS) == (min_cnt_reg & MIN_DIGITS))
    else $error("alarm event with minute field mismatched");

  hour_field_a: assert property ( // [R11]
    alarm_event && !hour_match_reg[MATCH_MASK_BIT]
    |-> (hour_match_reg & HOUR_DIGITS) == (hour_cnt_reg & HOUR_DIGITS))
    else $error("alarm event with hour field mismatched");

  entry_only_a: assert property ( // [R12]
    alarm_event |=> !alarm_event [*2])
    else $error("alarm event repeated while match persists");

  tick_to_eval_a: assert property ( // [R17]
    alarm_event |-> $past(time_tick))
    else $error("alarm event without a preceding minute update");

  status_sticky_a: assert property (
    alarm_event |=> irq_stat_reg[IRQ_ALARM_BIT] ##1
    (irq_stat_reg[IRQ_ALARM_BIT] || $past(wr_irq_stat)))
    else $error("alarm status bit not sticky");

endmodule

// ==== tb/rtcai_time_src.sv ====
`timescale 1ns/100ps

// Time base and shared pin model on the far side of the alarm block
module rtcai_time_src (
  input wire logic pclk,
  input wire logic alarm_irq_out_n,
  input wire logic alarm_irq_oe,
  output logic alarm_irq_in,
  output logic time_tick,
  output logic [7:0] time_minute,
  output logic [7:0] time_hour,
  output logic [7:0] time_day,
  output logic [7:0] time_weekday
);
  // Pull-up on the shared pin: a released pin reads high
  assign alarm_irq_in = alarm_irq_oe ? alarm_irq_out_n : 1'b1;

  initial
  begin
    time_tick = 1'b0;
    {time_minute, time_hour, time_day, time_weekday} = 32'h0000_0000;
  end

  // One minute update; values are only valid with the pulse, so they
  // are inverted afterwards to expose any late sampling
  task automatic tick(input logic [7:0] m, input logic [7:0] h,
                      input logic [7:0] d, input logic [7:0] w);
    @(posedge pclk);
    time_tick <= 1'b1;
    {time_minute, time_hour, time_day, time_weekday} <= {m, h, d, w};
    @(posedge pclk);
    time_tick <= 1'b0;
    {time_minute, time_hour, time_day, time_weekday} <= ~{m, h, d, w};
    repeat (3) @(posedge pclk);
    #1;
  endtask
endmodule

// ==== tb/tb_rtc_alarm_interrupt.sv ====
`timescale 1ns/100ps

module tb_rtc_alarm_interrupt
  import rtcai_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic time_tick, timer_event, timer_pulse_select, alarm_irq_in;
  logic alarm_irq_out_n, alarm_irq_oe, irq;
  logic [7:0] time_minute, time_hour, time_day, time_weekday;
  int fails, tests_run;

  rtcai_alarm dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .time_tick(time_tick), .time_minute(time_minute),
    .time_hour(time_hour), .time_day(time_day),
    .time_weekday(time_weekday), .timer_event(timer_event),
    .timer_pulse_select(timer_pulse_select), .alarm_irq_in(alarm_irq_in),
    .alarm_irq_out_n(alarm_irq_out_n), .alarm_irq_oe(alarm_irq_oe),
    .irq(irq));

  rtcai_time_src u_src (.pclk(pclk), .alarm_irq_out_n(alarm_irq_out_n),
    .alarm_irq_oe(alarm_irq_oe), .alarm_irq_in(alarm_irq_in),
    .time_tick(time_tick), .time_minute(time_minute),
    .time_hour(time_hour), .time_day(time_day),
    .time_weekday(time_weekday));

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx[5:0], 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd);
  endtask

  task automatic rdc(string n, logic [7:0] idx, logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000);
    chk(n, rd, exp);
  endtask

  // Pin checked once registers have settled; low means driven
  task automatic pin(string n, logic exp_oe);
    repeat (2) @(posedge pclk);
    #1;
    chk(n, {30'h0, alarm_irq_oe, alarm_irq_in}, {30'h0, exp_oe, ~exp_oe});
  endtask

  task automatic t_reset();
    rdc("ctrl", IDX_CTRL, 32'h0000_0000);
    for (int i = 9; i <= 12; i++) rdc("match", 8'(i), 32'h0000_0080);
    for (int i = 3; i <= 6; i++) rdc("counter", 8'(i), 32'h0000_0000);
    rdc("irq stat", IDX_IRQ_STAT, 32'h0000_0000);
    rdc("unmapped", 8'h20, 32'h0000_0000);
    chk("unmapped err", {31'h0, last_err}, 32'h0000_0001);
    wr(IDX_MIN_CNT, 32'h0000_0045);
    rdc("minute counter", IDX_MIN_CNT, 32'h0000_0045);
    $display("test reset done");
  endtask

  task automatic t_match();
    wr(IDX_CTRL, 32'h0000_0000);
    wr(IDX_MIN_MATCH, 32'h0000_0030);
    // Unused bit 6 set in the hour field must not spoil the compare
    wr(IDX_HOUR_MATCH, 32'h0000_0059);
    wr(IDX_CTRL, 32'h0000_0002);
    u_src.tick(8'h30, 8'h07, 8'h15, 8'h03);
    rdc("morning hour", IDX_CTRL, 32'h0000_0002);
    u_src.tick(8'h30, 8'h19, 8'h15, 8'h03);
    rdc("evening hour", IDX_CTRL, 32'h0000_000A);
    pin("pin on event", 1'b1);
    $display("test match done");
  endtask

  task automatic t_hold();
    repeat (20) @(posedge pclk);
    pin("pin held", 1'b1);
    wr(IDX_CTRL, 32'h0000_000A);
    rdc("flag write one", IDX_CTRL, 32'h0000_000A);
    wr(IDX_CTRL, 32'h0000_0008);
    pin("enable off", 1'b0);
    rdc("flag kept", IDX_CTRL, 32'h0000_0008);
    wr(IDX_CTRL, 32'h0000_000A);
    pin("enable on again", 1'b1);
    wr(IDX_CTRL, 32'h0000_0002);
    pin("flag cleared", 1'b0);
    rdc("flag write zero", IDX_CTRL, 32'h0000_0002);
    $display("test hold done");
  endtask

  task automatic t_edge();
    u_src.tick(8'h30, 8'h19, 8'h15, 8'h03);
    rdc("match persists", IDX_CTRL, 32'h0000_0002);
    u_src.tick(8'h31, 8'h19, 8'h15, 8'h03);
    // A software counter write must not start an evaluation
    wr(IDX_MIN_CNT, 32'h0000_0030);
    rdc("counter write", IDX_CTRL, 32'h0000_0002);
    u_src.tick(8'h30, 8'h19, 8'h15, 8'h03);
    rdc("match entered", IDX_CTRL, 32'h0000_000A);
    wr(IDX_CTRL, 32'h0000_0000);
    $display("test edge done");
  endtask

  task automatic t_mask();
    // Polling only: enable stays zero, flag watched
    wr(IDX_HOUR_MATCH, 32'h0000_0080);
    u_src.tick(8'h31, 8'h02, 8'h01, 8'h05);
    u_src.tick(8'h30, 8'h02, 8'h01, 8'h05);
    rdc("hour masked", IDX_CTRL, 32'h0000_0008);
    pin("polled pin", 1'b0);
    wr(IDX_CTRL, 32'h0000_0000);
    wr(IDX_MIN_MATCH, 32'h0000_0080);
    u_src.tick(8'h59, 8'h23, 8'h31, 8'h06);
    u_src.tick(8'h00, 8'h00, 8'h01, 8'h00);
    rdc("all masked", IDX_CTRL, 32'h0000_0000);
    $display("test mask done");
  endtask

  task automatic t_irq();
    wr(IDX_IRQ_MASK, 32'h0000_0001);
    wr(IDX_CTRL, 32'h0000_0001);
    @(posedge pclk);
    timer_event <= 1'b1;
    @(posedge pclk);
    timer_event <= 1'b0;
    pin("timer on pin", 1'b1);
    rdc("timer flag", IDX_CTRL, 32'h0000_0005);
    rdc("pin level", IDX_PIN_STAT, 32'h0000_0000);
    rdc("both sources", IDX_IRQ_STAT, 32'h0000_0003);
    chk("irq alarm", {31'h0, irq}, 32'h0000_0001);
    wr(IDX_IRQ_STAT, 32'h0000_0001);
    pin("stat cleared", 1'b1);
    chk("irq masked", {31'h0, irq}, 32'h0000_0000);
    wr(IDX_IRQ_MASK, 32'h0000_0003);
    pin("timer unmasked", 1'b1);
    chk("irq timer", {31'h0, irq}, 32'h0000_0001);
    // Clearing the timer flag and setting the pulse select together
    wr(IDX_CTRL, 32'h0000_0010);
    pin("timer cleared", 1'b0);
    chk("pulse select", {31'h0, timer_pulse_select}, 32'h0000_0001);
    rdc("pulse select reg", IDX_CTRL, 32'h0000_0010);
    $display("test irq done");
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Watchdog: the whole run needs well under 3000 cycles
  initial
  begin
    #200000;
    fails++;
    tally_and_finish();
  end

  initial
  begin
    {psel, penable, pwrite, timer_event} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_match();
    t_hold();
    t_edge();
    t_mask();
    t_irq();
    tally_and_finish();
  end
endmodule
